/* strt_pkg.sv */
package strt_pkg;

  // Trigger source select encodings, shared by input and output selection
  localparam int          SRC_W           = 6;
  localparam logic [5:0]  SRC_NONE        = 6'h00;
  localparam logic [5:0]  SRC_EXTERNAL    = 6'h01;
  localparam logic [5:0]  SRC_SOFTWARE    = 6'h02;
  localparam logic [5:0]  SRC_BP_BASE     = 6'h08;
  localparam logic [5:0]  SRC_STAR        = 6'h10;
  localparam logic [5:0]  SRC_BACK        = 6'h11;
  localparam logic [5:0]  SRC_FRONT       = 6'h12;
  localparam logic [5:0]  SRC_BACK_MOD1   = 6'h14;
  localparam logic [5:0]  SRC_FRONT_MOD1  = 6'h20;
  localparam logic [5:0]  SRC_IMMEDIATE   = 6'h3f;

  // Line vector layout: 8 backplane, star, back, front, 12 back modules, 12 front modules
  localparam int          NUM_BP          = 8;
  localparam int          NUM_MOD         = 12;
  localparam int          LINE_W          = 36;
  localparam int          POS_BP          = 0;
  localparam int          POS_STAR        = 8;
  localparam int          POS_BACK        = 9;
  localparam int          POS_FRONT       = 10;
  localparam int          POS_BACK_MOD    = 11;
  localparam int          POS_FRONT_MOD   = 23;
  // External line sits after the connector lines
  localparam int          POS_EXT         = 35;

  // Connection order modes
  localparam logic [1:0]  ORDER_NONE       = 2'h0;
  localparam logic [1:0]  OPEN_THEN_CLOSE  = 2'h1;
  localparam logic [1:0]  CLOSE_THEN_OPEN  = 2'h2;

  // APB register map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_SEL        = 8'h04;
  localparam logic [7:0]  ADDR_CMD        = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
  localparam logic [7:0]  ADDR_COUNT      = 8'h10;

  // CTRL fields
  localparam int          CTRL_ORDER_LSB  = 0;
  localparam int          CTRL_IN_EDGE    = 2;
  localparam int          CTRL_OUT_EDGE   = 3;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  // SEL fields
  localparam int          SEL_IN_LSB      = 0;
  localparam int          SEL_OUT_LSB     = 8;
  localparam logic [5:0]  SEL_IN_RESET    = 6'h3f;
  localparam logic [5:0]  SEL_OUT_RESET   = 6'h00;
  // CMD bits
  localparam int          CMD_START       = 0;
  localparam int          CMD_STOP        = 1;
  localparam int          CMD_SW_TRIG     = 2;
  localparam int          CMD_ENTRY_DONE  = 3;
  localparam int          CMD_LAST        = 4;

  // Output pulse width and relay settle time
  localparam int          PULSE_NS        = 64;
  localparam int          CLK_NS          = 8;
  localparam int          PULSE_CYC       = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SETTLE_NS       = 1000;
  localparam int          SETTLE_CYC      = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W           = 8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WAIT   = 3'b001,
    ST_FIRST  = 3'b011,
    ST_SECOND = 3'b010,
    ST_PULSE  = 3'b110,
    ST_ENTRY  = 3'b111
  } strt_state_t;

  // Map a select code to its one-hot line
  function automatic logic [LINE_W-1:0] src_onehot(input logic [5:0] s);
    logic [LINE_W-1:0] v;
    v = '0;
    if (s >= SRC_BP_BASE && s < SRC_BP_BASE + 6'(NUM_BP))
      v[POS_BP + int'(s - SRC_BP_BASE)] = 1'b1;
    else if (s == SRC_STAR)
      v[POS_STAR] = 1'b1;
    else if (s == SRC_BACK)
      v[POS_BACK] = 1'b1;
    else if (s == SRC_FRONT)
      v[POS_FRONT] = 1'b1;
    else if (s >= SRC_BACK_MOD1 && s < SRC_BACK_MOD1 + 6'(NUM_MOD))
      v[POS_BACK_MOD + int'(s - SRC_BACK_MOD1)] = 1'b1;
    else if (s >= SRC_FRONT_MOD1 && s < SRC_FRONT_MOD1 + 6'(NUM_MOD))
      v[POS_FRONT_MOD + int'(s - SRC_FRONT_MOD1)] = 1'b1;
    else if (s == SRC_EXTERNAL)
      v[POS_EXT] = 1'b1;
    return v;
  endfunction

endpackage

/* strt_edge_in.sv */
`timescale 1ns/1ns
module strt_edge_in
  import strt_pkg::*;
#(
  parameter int WIDTH = strt_pkg::LINE_W
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  // Asynchronous lines
  input  wire logic [WIDTH-1:0] line_i,
  input  wire logic             falling_i,
  // Qualified edge pulses
  output logic      [WIDTH-1:0] edge_o
);
  import strt_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] edge_nxt;

  // Rising or falling edge per selected polarity
  assign edge_nxt = falling_i ? (prev_r & ~sync_r) : (~prev_r & sync_r);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      edge_o <= '0;
    end
    else
    begin
      meta_r <= line_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
      edge_o <= edge_nxt;
    end
  end

endmodule

/* strt_router.sv */
// Contract
// - Backplane output select drives the advance pulse on that backplane line.
// - Star output select pulses star line before the next entry is processed.
// - Back or front output select routes pulse to that connector pin.
// - Module 1-12 back/front output selects pulse only the chosen line.
// - Output edge setting selects rising or falling output event.
// - Input edge setting selects rising or falling trigger recognition.
// - Order mode none does no automatic open or close.
// - Open-then-close opens old connections before closing new ones.
// - Close-then-open closes new connections before opening old ones.
// - Immediate input source advances without waiting for a trigger.
// - External source holds until an edge on the external input.
// - Software source stalls until the software trigger command.
// - Backplane source 0-7 waits for a qualified edge on that line.
// - Star source waits for a qualified edge on the star line.
// - Back or front source waits for an edge on that pin.
// - Module 1-12 sources wait only on the chosen module line.
// - Trigger wait only at separators; each trigger advances one entry.
// - Output select none produces no advance pulse.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
module strt_router
  import strt_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Trigger lines in
  input  wire logic                   ext_trig_i,
  input  wire logic [NUM_BP-1:0]      bp_trig_i,
  input  wire logic                   star_line_i,
  input  wire logic                   back_panel_line_i,
  input  wire logic                   front_panel_line_i,
  input  wire logic [NUM_MOD-1:0]     back_mod_line_i,
  input  wire logic [NUM_MOD-1:0]     front_mod_line_i,
  // Trigger lines out
  output logic                        ext_trig_o,
  output logic      [NUM_BP-1:0]      bp_trig_o,
  output logic      [NUM_BP-1:0]      bp_trig_oe_o,
  output logic                        star_line_o,
  output logic                        back_panel_line_o,
  output logic                        front_panel_line_o,
  output logic      [NUM_MOD-1:0]     back_mod_line_o,
  output logic      [NUM_MOD-1:0]     front_mod_line_o,
  // Relay sequencing and scan status
  output logic                        open_old_o,
  output logic                        close_new_o,
  output logic                        scanning_o,
  output logic                        waiting_trig_o
);
  import strt_pkg::*;

  logic [1:0]        connection_order_mode_r;
  logic              advance_in_edge_r;
  logic              advance_out_edge_r;
  logic [5:0]        advance_in_source_r;
  logic [5:0]        advance_out_source_r;
  logic              entry_rdy_r;
  logic              last_r;
  logic              sw_trig_r;
  strt_state_t       state_r;
  strt_state_t       state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [15:0]       advances_r;
  logic [LINE_W-1:0] out_lines_r;
  logic [LINE_W-1:0] out_lines_nxt;

  // Bus decode
  wire               wr_en      = psel & penable & pwrite;
  wire               setup_ph   = psel & ~penable;
  wire               rd_setup   = setup_ph & ~pwrite;
  wire               hit_ctrl   = (paddr == ADDR_CTRL);
  wire               hit_sel    = (paddr == ADDR_SEL);
  wire               hit_cmd    = (paddr == ADDR_CMD);
  wire               hit_status = (paddr == ADDR_STATUS);
  wire               hit_count  = (paddr == ADDR_COUNT);
  wire               hit_any    = hit_ctrl | hit_sel | hit_cmd | hit_status | hit_count;
  wire               cmd_wr     = wr_en & hit_cmd;
  wire               start_cmd  = cmd_wr & pwdata[CMD_START];
  wire               stop_cmd   = cmd_wr & pwdata[CMD_STOP];
  wire               swtrig_cmd = cmd_wr & pwdata[CMD_SW_TRIG];
  wire               entry_cmd  = cmd_wr & pwdata[CMD_ENTRY_DONE];

  // Input lines gathered in select order
  wire [LINE_W-1:0]  in_lines = {ext_trig_i, front_mod_line_i, back_mod_line_i,
                                 front_panel_line_i, back_panel_line_i, star_line_i, bp_trig_i};
  wire [LINE_W-1:0]  in_edges;

  strt_edge_in #(
    .WIDTH     (LINE_W)
  ) u_edge_in (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .line_i    (in_lines),
    .falling_i (advance_in_edge_r),
    .edge_o    (in_edges)
  );

  // One-hot input select and trigger qualification
  wire [LINE_W-1:0]  in_sel     = src_onehot(advance_in_source_r);
  wire               hw_trig    = |(in_sel & in_edges);
  wire               is_imm     = (advance_in_source_r == SRC_IMMEDIATE);
  wire               is_sw      = (advance_in_source_r == SRC_SOFTWARE);
  wire               trig_ok    = is_imm | (is_sw & sw_trig_r) | hw_trig;
  wire               pulse_done = (cnt_r == CNT_W'(PULSE_CYC - 1));
  wire               settle_done = (cnt_r == CNT_W'(SETTLE_CYC - 1));

  // Output select and idle level
  wire [LINE_W-1:0]  out_sel    = src_onehot(advance_out_source_r);
  wire [LINE_W-1:0]  idle_lvl   = {LINE_W{advance_out_edge_r}};
  wire [LINE_W-1:0]  act_lvl    = idle_lvl ^ out_sel;

  // Scan sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = '0;
    case (state_r)
      ST_IDLE:
        if (start_cmd)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (trig_ok)
          state_nxt = (connection_order_mode_r == ORDER_NONE) ? ST_PULSE : ST_FIRST;
      ST_FIRST:
        if (settle_done)
          state_nxt = ST_SECOND;
        else
          cnt_nxt = cnt_r + CNT_W'(1);
      ST_SECOND:
        if (settle_done)
          state_nxt = ST_PULSE;
        else
          cnt_nxt = cnt_r + CNT_W'(1);
      ST_PULSE:
        if (pulse_done)
          state_nxt = ST_ENTRY;
        else
          cnt_nxt = cnt_r + CNT_W'(1);
      ST_ENTRY:
        if (entry_rdy_r)
          state_nxt = last_r ? ST_IDLE : ST_WAIT;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (stop_cmd)
      state_nxt = ST_IDLE;
  end

  assign out_lines_nxt = (state_nxt == ST_PULSE) ? act_lvl : idle_lvl;

  // Relay order per mode
  wire               mode_otc   = (connection_order_mode_r == OPEN_THEN_CLOSE);
  wire               mode_cto   = (connection_order_mode_r == CLOSE_THEN_OPEN);
  wire               to_first   = (state_nxt == ST_FIRST);
  wire               to_second  = (state_nxt == ST_SECOND);
  wire               open_nxt   = (to_first & mode_otc) | (to_second & mode_cto);
  wire               close_nxt  = (to_second & mode_otc) | (to_first & mode_cto);
  // Scan step taken; stop keeps a pending software trigger
  wire               step_taken = (state_r == ST_WAIT) && (state_nxt != ST_WAIT) && !stop_cmd;
  wire               sw_take    = (state_r == ST_WAIT) && trig_ok && is_sw && !stop_cmd;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt == state_r) ? cnt_nxt : '0;
    end
  end

  // Relay order strobes
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      open_old_o  <= 1'b0;
      close_new_o <= 1'b0;
    end
    else
    begin
      open_old_o  <= open_nxt;
      close_new_o <= close_nxt;
    end
  end

  // Trigger output lines
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      out_lines_r <= '0;
      bp_trig_oe_o <= '0;
    end
    else
    begin
      out_lines_r  <= out_lines_nxt;
      bp_trig_oe_o <= out_sel[POS_BP +: NUM_BP];
    end
  end

  assign bp_trig_o          = out_lines_r[POS_BP +: NUM_BP];
  assign star_line_o        = out_lines_r[POS_STAR];
  assign back_panel_line_o  = out_lines_r[POS_BACK];
  assign front_panel_line_o = out_lines_r[POS_FRONT];
  assign back_mod_line_o    = out_lines_r[POS_BACK_MOD +: NUM_MOD];
  assign front_mod_line_o   = out_lines_r[POS_FRONT_MOD +: NUM_MOD];
  assign ext_trig_o         = out_lines_r[POS_EXT];

  // Configuration registers and command flags
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      connection_order_mode_r <= CTRL_RESET[1:0];
      advance_in_edge_r       <= 1'b0;
      advance_out_edge_r      <= 1'b0;
      advance_in_source_r     <= SEL_IN_RESET;
      advance_out_source_r    <= SEL_OUT_RESET;
      entry_rdy_r             <= 1'b0;
      last_r                  <= 1'b0;
      sw_trig_r               <= 1'b0;
      advances_r              <= '0;
    end
    else
    begin
      if (wr_en && hit_ctrl)
      begin
        connection_order_mode_r <= pwdata[CTRL_ORDER_LSB +: 2];
        advance_in_edge_r       <= pwdata[CTRL_IN_EDGE];
        advance_out_edge_r      <= pwdata[CTRL_OUT_EDGE];
      end
      if (wr_en && hit_sel)
      begin
        advance_in_source_r  <= pwdata[SEL_IN_LSB +: SRC_W];
        advance_out_source_r <= pwdata[SEL_OUT_LSB +: SRC_W];
      end
      // Set wins over consume
      if (swtrig_cmd)
        sw_trig_r <= 1'b1;
      else if (sw_take)
        sw_trig_r <= 1'b0;
      if (entry_cmd)
      begin
        entry_rdy_r <= 1'b1;
        last_r      <= pwdata[CMD_LAST];
      end
      else if (state_r == ST_ENTRY || state_r == ST_IDLE)
        entry_rdy_r <= 1'b0;
      if (start_cmd && state_r == ST_IDLE)
        advances_r <= '0;
      else if (step_taken)
        advances_r <= advances_r + 16'h0001;
    end
  end

  // APB read path, zero wait states
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prdata         <= '0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      scanning_o     <= 1'b0;
      waiting_trig_o <= 1'b0;
    end
    else
    begin
      pready         <= setup_ph;
      pslverr        <= setup_ph & ~hit_any;
      scanning_o     <= (state_nxt != ST_IDLE);
      waiting_trig_o <= (state_nxt == ST_WAIT);
      prdata         <= '0;
      if (rd_setup)
      begin
        if (hit_ctrl)
          prdata <= {28'h000_0000, advance_out_edge_r, advance_in_edge_r, connection_order_mode_r};
        else if (hit_sel)
          prdata <= {18'h0_0000, advance_out_source_r, 2'b00, advance_in_source_r};
        else if (hit_status)
          prdata <= {24'h00_0000, entry_rdy_r, sw_trig_r, 1'b0, 2'b00, state_r};
        else if (hit_count)
          prdata <= {16'h0000, advances_r};
      end
    end
  end

endmodule

/* strt_router_props.sv */
`timescale 1ns/1ns
module strt_router_props
  import strt_pkg::*;
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              srst_i,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [7:0]        paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  // Outputs watched
  input wire logic [NUM_BP-1:0] bp_trig_o,
  input wire logic [NUM_BP-1:0] bp_trig_oe_o,
  input wire logic              open_old_o,
  input wire logic              close_new_o,
  input wire logic              scanning_o,
  input wire logic              waiting_trig_o
);
  int open_run_r;
  int close_run_r;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Length of the current relay phase
  always_ff @(posedge clk_i)
  begin
    open_run_r  <= (srst_i || !open_old_o) ? 0 : open_run_r + 1;
    close_run_r <= (srst_i || !close_new_o) ? 0 : close_run_r + 1;
  end
  AST_RDY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_ACCESS_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  AST_UNMAPPED: assert property (pready && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_OPEN_LEN: assert property ($fell(open_old_o) |-> open_run_r == SETTLE_CYC)
    else $error("open phase length wrong");
  AST_CLOSE_LEN: assert property ($fell(close_new_o) |-> close_run_r == SETTLE_CYC)
    else $error("close phase length wrong");
  AST_PHASE_EXCL: assert property (!(open_old_o && close_new_o))
    else $error("open and close overlap");
  AST_WAIT_NO_RELAY: assert property (waiting_trig_o |-> !open_old_o && !close_new_o)
    else $error("relay phase during trigger wait");
  AST_WAIT_SCAN: assert property (waiting_trig_o |-> scanning_o)
    else $error("trigger wait while idle");
  AST_OE_ONE: assert property ($onehot0(bp_trig_oe_o))
    else $error("more than one backplane enable");
  AST_BP_ROUTE: assert property (bp_trig_o != 8'h00 && bp_trig_o != 8'hff |-> bp_trig_oe_o != 8'h00)
    else $error("backplane pulse without enable");
  C_OPEN: cover property ($rose(open_old_o));
  C_CLOSE: cover property ($rose(close_new_o));
  C_WAIT: cover property ($rose(waiting_trig_o));
  C_ERR: cover property (pslverr);
endmodule

/* strt_trig_partner.sv */
`timescale 1ns/1ns
module strt_trig_partner
  import strt_pkg::*;
(
  // Clock and request
  input  wire logic              clk_i,
  input  wire logic              fire_i,
  input  wire logic [5:0]        idx_i,
  input  wire logic              idle_i,
  input  wire logic [3:0]        delay_i,
  // Trigger lines towards the device
  output logic      [LINE_W-1:0] lines_o = '0
);
  int       wait_c = 0;
  int       hold_c = 0;
  logic [5:0] idx_r = '0;
  // Delayed four-cycle trigger, lines rest at the idle level
  always @(posedge clk_i)
  begin
    if (fire_i)
    begin
      wait_c <= int'(delay_i) + 1;
      idx_r  <= idx_i;
    end
    else if (wait_c > 1)
      wait_c <= wait_c - 1;
    else if (wait_c == 1)
    begin
      lines_o <= {LINE_W{idle_i}} ^ (36'h1 << idx_r);
      hold_c  <= 4;
      wait_c  <= 0;
    end
    else if (hold_c > 1)
      hold_c <= hold_c - 1;
    else
    begin
      hold_c  <= 0;
      lines_o <= {LINE_W{idle_i}};
    end
  end
endmodule

/* strt_router_test.sv */
`timescale 1ns/1ns
module strt_router_test;
  import strt_pkg::*;
  logic clk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, fire = 0, pidle = 0;
  logic [5:0] fidx = '0;
  logic [3:0] fdly = '0;
  logic [LINE_W-1:0] pl;
  logic ext_trig_o, star_line_o, back_panel_line_o, front_panel_line_o;
  logic open_old_o, close_new_o, scanning_o, waiting_trig_o;
  logic [7:0] bp_trig_o, bp_trig_oe_o;
  logic [11:0] back_mod_line_o, front_mod_line_o;
  wire [35:0] ov = {ext_trig_o, front_mod_line_o, back_mod_line_o, front_panel_line_o,
                    back_panel_line_o, star_line_o, bp_trig_o};
  int miscompares = 0, n_tests = 0, exp_q[$];
  always #4 clk_i = ~clk_i;
  strt_trig_partner u_partner (.clk_i, .fire_i(fire), .idx_i(fidx), .idle_i(pidle), .delay_i(fdly), .lines_o(pl));
  strt_router DUT (.clk_i, .srst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_trig_i(pl[35]), .bp_trig_i(pl[7:0]), .star_line_i(pl[8]), .back_panel_line_i(pl[9]),
    .front_panel_line_i(pl[10]), .back_mod_line_i(pl[22:11]), .front_mod_line_i(pl[34:23]),
    .ext_trig_o, .bp_trig_o, .bp_trig_oe_o, .star_line_o, .back_panel_line_o, .front_panel_line_o,
    .back_mod_line_o, .front_mod_line_o, .open_old_o, .close_new_o, .scanning_o, .waiting_trig_o);
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable <= 1;
    for (k = 0; k < 16 && pready !== 1'b1; k++)
      @(posedge clk_i);
    if (k == 16)
    begin
      miscompares++;
      complete_run();
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Line position of a select code, -1 for none, software, immediate
  function automatic int line_of(input int s);
    if (s >= 8 && s < 16) return s - 8;
    if (s >= 16 && s < 19) return s - 8;
    if (s >= 20 && s < 32) return s - 9;
    if (s >= 32 && s < 44) return s - 9;
    return (s == 1) ? 35 : -1;
  endfunction
  task automatic fire_line(input int p);
    @(posedge clk_i);
    {fire, fidx, fdly} <= {1'b1, 6'(p), 4'($urandom_range(0, 9))};
    @(posedge clk_i);
    fire <= 0;
  endtask
  task automatic run_case(input int i, input int ins, input int outs);
    logic [31:0] r, c0;
    logic e;
    logic [35:0] idle, expv;
    int mode, ie, oe, pin, q, t_op, t_cl, t_pu, width, bad, c;
    {mode, ie, oe, pin} = {i % 3, i & 1, (i >> 1) & 1, line_of(ins)};
    {t_op, t_cl, t_pu, width, bad} = {-1, -1, -1, 0, 0};
    idle = {36{1'(oe)}};
    @(posedge clk_i);
    pidle <= 1'(ie);
    repeat (6) @(posedge clk_i);
    apb(1, ADDR_CTRL, 32'(mode + ie * 4 + oe * 8), r, e);
    apb(1, ADDR_SEL, 32'(outs * 256 + ins), r, e);
    apb(1, ADDR_CMD, 32'h0000_0001, r, e);
    c0 = 0;
    if (ins != SRC_IMMEDIATE)
    begin
      fire_line((pin < 0) ? 0 : (pin + 5) % 36);
      repeat (16) @(posedge clk_i);
      check(36'(waiting_trig_o), 36'h1);
      check(ov, idle);
      apb(0, ADDR_COUNT, 0, c0, e);
      apb(0, ADDR_STATUS, 0, r, e);
      check(36'(r), 36'(ST_WAIT));
      if (ins == SRC_SOFTWARE) apb(1, ADDR_CMD, 32'h0000_0004, r, e);
      else fire_line(pin);
    end
    exp_q.push_back(line_of(outs));
    q = exp_q.pop_front();
    expv = idle;
    if (q >= 0) expv[q] = ~idle[q];
    for (c = 0; c < 400; c++)
    begin
      @(negedge clk_i);
      if (open_old_o === 1'b1 && t_op < 0) t_op = c;
      if (close_new_o === 1'b1 && t_cl < 0) t_cl = c;
      if (ov !== idle && t_pu < 0) t_pu = c;
      width += (ov !== idle);
      bad += (ov !== idle && ov !== expv);
    end
    check(36'(width), (q >= 0) ? 36'(PULSE_CYC) : 36'h0);
    check(36'(bad), 36'h0);
    check(36'(bp_trig_oe_o), (q >= 0 && q < 8) ? 36'(1 << q) : 36'h0);
    if (mode == 0) check(36'(t_op < 0 && t_cl < 0), 36'h1);
    if (mode == 1) check(36'(t_op >= 0 && t_op < t_cl && (q < 0 || t_cl < t_pu)), 36'h1);
    if (mode == 2) check(36'(t_cl >= 0 && t_cl < t_op && (q < 0 || t_op < t_pu)), 36'h1);
    apb(0, ADDR_COUNT, 0, r, e);
    check(36'(r[15:0]), 36'(c0[15:0] + 16'h1));
    apb(1, ADDR_CMD, 32'h0000_0018, r, e);
    repeat (4) @(posedge clk_i);
    check(36'(scanning_o), 36'h0);
    $display("case %0d done", i);
  endtask
  initial
  begin
    logic [31:0] r;
    logic e;
    int ins_t[9], out_t[9];
    void'($urandom(86));
    ins_t = '{SRC_IMMEDIATE, SRC_EXTERNAL, SRC_SOFTWARE, int'(SRC_BP_BASE) + $urandom_range(0, 7), SRC_STAR,
              SRC_BACK, SRC_FRONT, int'(SRC_BACK_MOD1) + $urandom_range(0, 11),
              int'(SRC_FRONT_MOD1) + $urandom_range(0, 11)};
    out_t = '{SRC_STAR, SRC_NONE, SRC_EXTERNAL, int'(SRC_FRONT_MOD1) + $urandom_range(0, 11),
              int'(SRC_BP_BASE) + $urandom_range(0, 7), int'(SRC_BACK_MOD1) + $urandom_range(0, 11),
              SRC_BACK, SRC_FRONT, int'(SRC_BP_BASE) + $urandom_range(0, 7)};
    repeat (6) @(posedge clk_i);
    srst_i <= 0;
    check(ov, 36'h0);
    apb(0, ADDR_CTRL, 0, r, e);
    check(36'(r), 36'h0);
    apb(0, ADDR_SEL, 0, r, e);
    check(36'(r), 36'h0_0000_003f);
    apb(0, ADDR_COUNT, 0, r, e);
    check(36'(r), 36'h0);
    apb(0, 8'h14, 0, r, e);
    check({e, r}, 36'h1_0000_0000);
    $display("reset test done");
    for (int i = 0; i < 9; i++)
      run_case(i, ins_t[i], out_t[i]);
    // Stop in a trigger wait, then a reset in mid-scan
    apb(1, ADDR_SEL, 32'(SRC_EXTERNAL), r, e);
    apb(1, ADDR_CMD, 32'h0000_0001, r, e);
    repeat (2) @(posedge clk_i);
    check(36'(waiting_trig_o), 36'h1);
    apb(1, ADDR_CMD, 32'h0000_0002, r, e);
    repeat (2) @(posedge clk_i);
    check(36'(scanning_o), 36'h0);
    apb(1, ADDR_CMD, 32'h0000_0001, r, e);
    srst_i <= 1;
    repeat (6) @(posedge clk_i);
    srst_i <= 0;
    check(ov, 36'h0);
    check(36'(scanning_o), 36'h0);
    apb(0, ADDR_SEL, 0, r, e);
    check(36'(r), 36'h0_0000_003f);
    $display("stop and reset test done");
    complete_run();
  end
endmodule
bind strt_router strt_router_props u_props (.clk_i, .srst_i, .psel, .penable, .paddr, .pready, .pslverr,
  .bp_trig_o, .bp_trig_oe_o, .open_old_o, .close_new_o, .scanning_o, .waiting_trig_o);
